// ==== common/mra_defines.vh ====
// constants for the memory refresh and bus arbitration glue
`ifndef MRA_DEFINES_VH
`define MRA_DEFINES_VH
`define MRA_CLK_MHZ        50
`define MRA_REFRESH_US     15
`define MRA_REFRESH_CYC    ((`MRA_REFRESH_US) * (`MRA_CLK_MHZ))
`define MRA_ROW_W          8
`define MRA_ROW_LAST       8'hff
`define MRA_ROW_ZERO       8'h00
`define MRA_STROBE_CYC     4'h4
`define MRA_DMA_DIV        4'hc
`define MRA_PAGE_RESET     8'h00
`define MRA_ERR_BIT        7
`define MRA_ADDR_W         24
`define MRA_SYNC_IDLE      5'h10
`endif

// ==== hdl/mra_parity_lane.v ====
// even parity generation and checking for one memory byte lane
`timescale 1ns/1ps
module mra_parity_lane (
  // data and stored parity
  input  wire [7:0] data_i,
  input  wire       par_in_i,
  // parity outputs
  output wire       par_out_o,
  output wire       odd_o
);
  assign par_out_o = ^data_i;
  assign odd_o     = (^data_i) ^ par_in_i;
endmodule

// ==== hdl/mra_arbiter.v ====
// memory refresh engine, bus arbiter, DMA address glue and parity check
`timescale 1ns/1ps
`include "mra_defines.vh"
module mra_arbiter (
  // clock and reset
  input  wire        CLOCK_I,
  input  wire        RST_I,
  // refresh tick from interval timer, async pin
  input  wire        REFRESH_TICK_I,
  // processor hold handshake
  input  wire        CPU_HOLD_ACK_I,
  output reg         CPU_HOLD_REQUEST_O,
  // DMA side
  input  wire        DMA_HOLD_REQUEST_I,
  input  wire        DMA_WORD_MODE_I,
  input  wire [7:0]  CHANNEL_DMA_REQUEST_I,
  input  wire        DMA_UPPER_ADDR_STROBE_I,
  input  wire [7:0]  DMA_DATA_I,
  input  wire [15:0] DMA_ADDR_I,
  input  wire        IO_DEVICE_READY_I,
  output reg         DMA_GRANT_O,
  output reg  [7:0]  CHANNEL_DMA_ACK_O,
  output reg         DMA_READY_O,
  // system address and strobes
  output reg  [23:0] SYS_ADDR_O,
  output reg         SYS_ADDR_OE_O,
  output reg         SYS_MEM_READ_N_O,
  output reg         REFRESH_ACTIVE_O,
  // memory data and parity
  input  wire [15:0] MEM_DATA_BUS_I,
  input  wire        MEM_WRITE_I,
  input  wire        MEM_READ_I,
  input  wire        PARITY_BIT_IN_LO_I,
  input  wire        PARITY_BIT_IN_HI_I,
  output reg         PARITY_BIT_OUT_LO_O,
  output reg         PARITY_BIT_OUT_HI_O,
  output reg         PARITY_BIT_OE_O,
  // error reporting
  input  wire        EXT_MEM_CHECK_N_I,
  output reg         NMI_O,
  output reg         PARITY_ERROR_FLAG_O,
  // peripheral bus access to page register and status
  input  wire        PAGE_WRITE_I,
  input  wire        STATUS_READ_I,
  input  wire        ERROR_CLEAR_I,
  input  wire [7:0]  PERIPH_DATA_BUS_I,
  output reg  [7:0]  PERIPH_DATA_BUS_O,
  output reg         PERIPH_DATA_BUS_OE_O
);

  localparam ST_IDLE   = 5'b00001;
  localparam ST_HOLD   = 5'b00010;
  localparam ST_STROBE = 5'b00100;
  localparam ST_DONE   = 5'b01000;
  localparam ST_DMA    = 5'b10000;

  // pin synchronisers, first stage read only by the second
  reg [4:0] sync1_r;
  reg [4:0] sync2_r;
  // reset to the idle pin levels so no false edge follows reset
  always @(posedge CLOCK_I) begin
    if (RST_I) begin
      sync1_r <= `MRA_SYNC_IDLE;
      sync2_r <= `MRA_SYNC_IDLE;
    end else begin
      sync1_r <= {EXT_MEM_CHECK_N_I, IO_DEVICE_READY_I,
                  DMA_UPPER_ADDR_STROBE_I, CPU_HOLD_ACK_I,
                  REFRESH_TICK_I};
      sync2_r <= sync1_r;
    end
  end
  wire tick_s    = sync2_r[0];
  wire ack_s     = sync2_r[1];
  wire stb_s     = sync2_r[2];
  wire ready_s   = sync2_r[3];
  wire chk_n_s   = sync2_r[4];

  reg tick_d_r;
  always @(posedge CLOCK_I) begin
    if (RST_I)
      tick_d_r <= 1'b0;
    else
      tick_d_r <= tick_s;
  end
  wire tick_rise = tick_s & ~tick_d_r;

  // refresh tick latched until the row is done; a tick rising during a
  // refresh merges into it, ticks are far apart so none goes missing
  reg tick_pend_r;

  // lowest requesting channel of the active controller
  function [7:0] mra_pick;
    input [7:0] req;
    input       word;
    reg   [3:0] sub;
    begin
      sub = word ? req[7:4] : req[3:0];
      mra_pick = 8'h00;
      if (sub[0])
        mra_pick = word ? 8'h10 : 8'h01;
      else if (sub[1])
        mra_pick = word ? 8'h20 : 8'h02;
      else if (sub[2])
        mra_pick = word ? 8'h40 : 8'h04;
      else if (sub[3])
        mra_pick = word ? 8'h80 : 8'h08;
    end
  endfunction

  // status byte: only the error bit is defined, the rest read as zero
  function [7:0] mra_status;
    input err;
    begin
      mra_status = 8'h00;
      mra_status[`MRA_ERR_BIT] = err;
    end
  endfunction

  reg [4:0]               state_r;
  reg [4:0]               state_nxt;
  reg [`MRA_ROW_W-1:0]    row_r;
  reg [3:0]               strobe_cnt_r;
  reg [7:0]               page_r;
  reg [7:0]               upper_r;
  reg                     err_r;
  reg                     stb_d_r;
  reg                     word_r;

  // mode straight from the pin in the granting cycle, so ack and
  // address are right from the first granted cycle on
  wire word_now = (state_r == ST_IDLE) ? DMA_WORD_MODE_I : word_r;

  always @* begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE: begin
        // a pending tick beats a DMA request raised in the same cycle;
        // letting both wait would lock the bus with neither served
        if (tick_pend_r)
          state_nxt = ST_HOLD;
        else if (DMA_HOLD_REQUEST_I)
          state_nxt = ST_DMA;
      end
      ST_HOLD: begin
        if (ack_s)
          state_nxt = ST_STROBE;
      end
      ST_STROBE: begin
        if (strobe_cnt_r == `MRA_STROBE_CYC)
          state_nxt = ST_DONE;
      end
      ST_DONE: begin
        if (~ack_s)
          state_nxt = ST_IDLE;
      end
      ST_DMA: begin
        if (~DMA_HOLD_REQUEST_I)
          state_nxt = ST_IDLE;
      end
      default: state_nxt = ST_IDLE;
    endcase
  end

  always @(posedge CLOCK_I) begin
    if (RST_I) begin
      state_r      <= ST_IDLE;
      tick_pend_r  <= 1'b0;
      row_r        <= `MRA_ROW_ZERO;
      strobe_cnt_r <= 4'h0;
    end else begin
      state_r <= state_nxt;
      // a new tick wins over the clear at row completion
      if (tick_rise)
        tick_pend_r <= 1'b1;
      else if (state_r == ST_DONE)
        tick_pend_r <= 1'b0;
      if (state_r == ST_STROBE)
        strobe_cnt_r <= strobe_cnt_r + 4'h1;
      else
        strobe_cnt_r <= 4'h0;
      // step once per refresh strobe, wraps past the last row
      if (state_r == ST_STROBE && state_nxt == ST_DONE) begin
        if (row_r == `MRA_ROW_LAST)
          row_r <= `MRA_ROW_ZERO;
        else
          row_r <= row_r + 8'h01;
      end
    end
  end

  // arbiter outputs
  always @(posedge CLOCK_I) begin
    if (RST_I) begin
      CPU_HOLD_REQUEST_O <= 1'b0;
      REFRESH_ACTIVE_O   <= 1'b0;
      SYS_MEM_READ_N_O   <= 1'b1;
      DMA_GRANT_O        <= 1'b0;
      CHANNEL_DMA_ACK_O  <= 8'h00;
      word_r             <= 1'b0;
    end else begin
      CPU_HOLD_REQUEST_O <= (state_nxt == ST_HOLD) |
                            (state_nxt == ST_STROBE);
      REFRESH_ACTIVE_O   <= (state_nxt == ST_STROBE);
      SYS_MEM_READ_N_O   <= ~(state_nxt == ST_STROBE);
      DMA_GRANT_O        <= (state_nxt == ST_DMA);
      if (state_r == ST_IDLE)
        word_r <= DMA_WORD_MODE_I;
      if (state_nxt == ST_DMA)
        CHANNEL_DMA_ACK_O <= mra_pick(CHANNEL_DMA_REQUEST_I,
                                      word_now);
      else
        CHANNEL_DMA_ACK_O <= 8'h00;
    end
  end

  // page register and upper address latch
  always @(posedge CLOCK_I) begin
    if (RST_I) begin
      page_r  <= `MRA_PAGE_RESET;
      upper_r <= 8'h00;
      stb_d_r <= 1'b0;
    end else begin
      stb_d_r <= stb_s;
      if (PAGE_WRITE_I)
        page_r <= PERIPH_DATA_BUS_I;
      if (stb_s)
        upper_r <= DMA_DATA_I;
    end
  end

  // address drive, refresh row gated only during refresh
  always @(posedge CLOCK_I) begin
    if (RST_I) begin
      SYS_ADDR_O    <= 24'h000000;
      SYS_ADDR_OE_O <= 1'b0;
    end else begin
      if (state_nxt == ST_STROBE) begin
        SYS_ADDR_O    <= {16'h0000, row_r};
        SYS_ADDR_OE_O <= 1'b1;
      end else if (state_nxt == ST_DMA) begin
        SYS_ADDR_OE_O <= 1'b1;
        // word mode: A0 held low, page bit 0 has no address line left
        if (word_now)
          SYS_ADDR_O <= {page_r[7:1], upper_r,
                         DMA_ADDR_I[7:0], 1'b0};
        else
          SYS_ADDR_O <= {page_r, upper_r, DMA_ADDR_I[7:0]};
      end else begin
        SYS_ADDR_O    <= 24'h000000;
        SYS_ADDR_OE_O <= 1'b0;
      end
    end
  end

  // DMA wait flip-flop: ready low between cycles until device ready
  always @(posedge CLOCK_I) begin
    if (RST_I)
      DMA_READY_O <= 1'b0;
    else if (state_r != ST_DMA)
      DMA_READY_O <= 1'b0;
    else if (ready_s)
      DMA_READY_O <= 1'b1;
    else if (stb_s & ~stb_d_r)
      DMA_READY_O <= 1'b0;
  end

  // parity lanes, lane 0 on data bits 7:0, lane 1 on bits 15:8
  wire [1:0] par_lane;
  wire [1:0] odd_lane;
  wire [1:0] par_in_lane = {PARITY_BIT_IN_HI_I, PARITY_BIT_IN_LO_I};
  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : g_lane
      mra_parity_lane mra_parity_lane_inst (
        .data_i    (MEM_DATA_BUS_I[g*8 +: 8]),
        .par_in_i  (par_in_lane[g]),
        .par_out_o (par_lane[g]),
        .odd_o     (odd_lane[g])
      );
    end
  endgenerate

  always @(posedge CLOCK_I) begin
    if (RST_I) begin
      PARITY_BIT_OUT_LO_O <= 1'b0;
      PARITY_BIT_OUT_HI_O <= 1'b0;
      PARITY_BIT_OE_O     <= 1'b0;
      err_r               <= 1'b0;
      NMI_O               <= 1'b0;
      PARITY_ERROR_FLAG_O <= 1'b0;
    end else begin
      PARITY_BIT_OUT_LO_O <= par_lane[0];
      PARITY_BIT_OUT_HI_O <= par_lane[1];
      // only writes store parity, reads discard it
      PARITY_BIT_OE_O     <= MEM_WRITE_I;
      // an error in the cycle of a clear keeps the latch set
      if (MEM_READ_I & (odd_lane[0] | odd_lane[1]))
        err_r <= 1'b1;
      else if (ERROR_CLEAR_I)
        err_r <= 1'b0;
      PARITY_ERROR_FLAG_O <= err_r;
      NMI_O <= err_r | ~chk_n_s;
    end
  end

  // status buffer onto peripheral bus
  always @(posedge CLOCK_I) begin
    if (RST_I) begin
      PERIPH_DATA_BUS_O    <= 8'h00;
      PERIPH_DATA_BUS_OE_O <= 1'b0;
    end else begin
      PERIPH_DATA_BUS_O    <= mra_status(err_r);
      PERIPH_DATA_BUS_OE_O <= STATUS_READ_I;
    end
  end

endmodule

// ==== testbench/mra_cpu_model.sv ====
// host processor model answering the hold handshake
`timescale 1ns/1ps
module mra_cpu_model (
  // clock and reset
  input  wire CLOCK_I,
  input  wire RST_I,
  // hold handshake
  input  wire hold_req_i,
  input  wire slow_i,
  output reg  hold_ack_o
);
  reg [2:0] wait_r;
  // slow mode stands for a processor finishing its own bus cycle first
  always @(posedge CLOCK_I) begin
    if (RST_I || !hold_req_i) begin
      hold_ack_o <= 1'b0;
      wait_r     <= slow_i ? 3'h5 : 3'h0;
    end else if (wait_r != 3'h0)
      wait_r <= wait_r - 3'h1;
    else
      hold_ack_o <= 1'b1;
  end
endmodule

// ==== testbench/mra_arb_checker.sv ====
// assertions on refresh, arbitration and parity behaviour
`timescale 1ns/1ps
module mra_arb_checker (
  input wire        CLOCK_I, RST_I, CPU_HOLD_ACK_I, CPU_HOLD_REQUEST_O,
  input wire        DMA_HOLD_REQUEST_I, DMA_GRANT_O, DMA_READY_O,
  input wire [7:0]  CHANNEL_DMA_ACK_O,
  input wire [23:0] SYS_ADDR_O,
  input wire        SYS_ADDR_OE_O, SYS_MEM_READ_N_O, REFRESH_ACTIVE_O,
  input wire [15:0] MEM_DATA_BUS_I,
  input wire        MEM_WRITE_I, MEM_READ_I, PARITY_BIT_IN_LO_I,
  input wire        PARITY_BIT_IN_HI_I,
  input wire        PARITY_BIT_OUT_LO_O, PARITY_BIT_OUT_HI_O,
  input wire        PARITY_BIT_OE_O, EXT_MEM_CHECK_N_I, NMI_O,
  input wire        PARITY_ERROR_FLAG_O
);
  wire       lo_par = ^MEM_DATA_BUS_I[7:0];
  wire       hi_par = ^MEM_DATA_BUS_I[15:8];
  reg  [7:0] last_row_r;
  reg        seen_r;
  always @(posedge CLOCK_I) begin
    if (RST_I)
      seen_r <= 1'b0;
    else if ($rose(REFRESH_ACTIVE_O)) begin
      seen_r     <= 1'b1;
      last_row_r <= SYS_ADDR_O[7:0];
    end
  end
  default clocking @(posedge CLOCK_I); endclocking
  default disable iff (RST_I);
  sequence s_strobe;
    REFRESH_ACTIVE_O && !SYS_MEM_READ_N_O && SYS_ADDR_OE_O &&
      SYS_ADDR_O[23:8] == 16'h0000;
  endsequence
  property p_after_ack;
    $rose(REFRESH_ACTIVE_O) |-> CPU_HOLD_ACK_I && CPU_HOLD_REQUEST_O;
  endproperty
  a_after_ack: assert property (p_after_ack)
    else $error("refresh without hold ack");
  property p_strobe;
    $rose(REFRESH_ACTIVE_O) |-> s_strobe [*5] ##1
      (!REFRESH_ACTIVE_O && !CPU_HOLD_REQUEST_O);
  endproperty
  a_strobe: assert property (p_strobe)
    else $error("bad refresh strobe");
  property p_row_step;
    $rose(REFRESH_ACTIVE_O) && seen_r |->
      SYS_ADDR_O[7:0] == last_row_r + 8'h01;
  endproperty
  a_row_step: assert property (p_row_step)
    else $error("row did not step");
  property p_hold_req;
    $rose(CPU_HOLD_REQUEST_O) |-> !DMA_GRANT_O &&
      !$past(DMA_GRANT_O);
  endproperty
  a_hold_req: assert property (p_hold_req)
    else $error("hold request during DMA");
  property p_grant_excl;
    DMA_GRANT_O |-> !REFRESH_ACTIVE_O && !CPU_HOLD_REQUEST_O;
  endproperty
  a_grant_excl: assert property (p_grant_excl)
    else $error("grant during refresh");
  property p_grant_ack;
    $rose(DMA_GRANT_O) |-> $onehot(CHANNEL_DMA_ACK_O) && !DMA_READY_O;
  endproperty
  a_grant_ack: assert property (p_grant_ack)
    else $error("bad ack at grant");
  property p_par_gen;
    MEM_WRITE_I |=> PARITY_BIT_OE_O && PARITY_BIT_OUT_LO_O ==
      $past(lo_par) && PARITY_BIT_OUT_HI_O == $past(hi_par);
  endproperty
  a_par_gen: assert property (p_par_gen)
    else $error("bad parity out");
  property p_err_latch;
    MEM_READ_I && ((lo_par ^ PARITY_BIT_IN_LO_I) ||
      (hi_par ^ PARITY_BIT_IN_HI_I)) |->
      ##[1:2] (PARITY_ERROR_FLAG_O && NMI_O);
  endproperty
  a_err_latch: assert property (p_err_latch)
    else $error("parity error not latched");
  property p_ext_nmi;
    !EXT_MEM_CHECK_N_I [*4] |=> NMI_O;
  endproperty
  a_ext_nmi: assert property (p_ext_nmi)
    else $error("no nmi on memory check");
endmodule
bind mra_arbiter mra_arb_checker mra_arb_checker_inst (.*);

// ==== testbench/tb_mra_arbiter.sv ====
// testbench for the refresh and bus arbitration glue
`timescale 1ns/1ps
module tb_mra_arbiter;
  reg         CLOCK_I = 1'b0, RST_I = 1'b1, REFRESH_TICK_I = 1'b0;
  reg         DMA_HOLD_REQUEST_I = 1'b0, DMA_WORD_MODE_I = 1'b0;
  reg         DMA_UPPER_ADDR_STROBE_I = 1'b0, IO_DEVICE_READY_I = 1'b0;
  reg         MEM_WRITE_I = 1'b0, MEM_READ_I = 1'b0;
  reg         PARITY_BIT_IN_LO_I = 1'b0, PARITY_BIT_IN_HI_I = 1'b0;
  reg         PAGE_WRITE_I = 1'b0, STATUS_READ_I = 1'b0;
  reg         ERROR_CLEAR_I = 1'b0, EXT_MEM_CHECK_N_I = 1'b1, slow = 1'b0;
  reg  [7:0]  CHANNEL_DMA_REQUEST_I = 8'h00, DMA_DATA_I = 8'h00;
  reg  [7:0]  PERIPH_DATA_BUS_I = 8'h00;
  reg  [15:0] DMA_ADDR_I = 16'h0000, MEM_DATA_BUS_I = 16'h0000;
  wire        CPU_HOLD_ACK_I, CPU_HOLD_REQUEST_O, DMA_GRANT_O, DMA_READY_O;
  wire        SYS_ADDR_OE_O, SYS_MEM_READ_N_O, REFRESH_ACTIVE_O, NMI_O;
  wire        PARITY_BIT_OUT_LO_O, PARITY_BIT_OUT_HI_O, PARITY_BIT_OE_O;
  wire        PARITY_ERROR_FLAG_O, PERIPH_DATA_BUS_OE_O;
  wire [7:0]  CHANNEL_DMA_ACK_O, PERIPH_DATA_BUS_O;
  wire [23:0] SYS_ADDR_O;
  integer     failures = 0, n_compared = 0, i, k;
  mra_arbiter mra_arbiter_inst (.*);
  mra_cpu_model mra_cpu_model_inst (.CLOCK_I(CLOCK_I), .RST_I(RST_I),
    .hold_req_i(CPU_HOLD_REQUEST_O), .slow_i(slow),
    .hold_ack_o(CPU_HOLD_ACK_I));
  always #10 CLOCK_I = ~CLOCK_I;
  function logic pick(input integer w);
    case (w)
      0: pick = REFRESH_ACTIVE_O;
      1: pick = DMA_GRANT_O;
      2: pick = DMA_READY_O;
      default: pick = NMI_O;
    endcase
  endfunction
  task chk(input string what, input [23:0] exp, input [23:0] got);
    begin
      n_compared = n_compared + 1;
      if (got !== exp) begin
        failures = failures + 1;
        $display("unexpected %s: expected %h seen %h", what, exp, got);
      end
    end
  endtask
  task wait_on(input integer w, input logic lvl, input string what);
    begin
      k = 0;
      while (pick(w) !== lvl && k < 60) begin
        @(negedge CLOCK_I);
        k = k + 1;
      end
      chk(what, lvl, pick(w));
    end
  endtask
  task refresh(input [7:0] row);
    begin
      @(negedge CLOCK_I) REFRESH_TICK_I = 1'b1;
      repeat (3) @(negedge CLOCK_I);
      REFRESH_TICK_I = 1'b0;
      wait_on(0, 1'b1, "refresh");
      chk("row", {16'h0000, row}, SYS_ADDR_O);
      chk("mem_read_n", 1'b0, SYS_MEM_READ_N_O);
      wait_on(0, 1'b0, "refresh_end");
      chk("hold_req", 1'b0, CPU_HOLD_REQUEST_O);
      repeat (6) @(negedge CLOCK_I);
    end
  endtask
  task dma(input logic word, input [7:0] ack, input [23:0] addr);
    begin
      DMA_WORD_MODE_I = word;
      CHANNEL_DMA_REQUEST_I = 8'h66;
      DMA_HOLD_REQUEST_I = 1'b1;
      wait_on(1, 1'b1, "grant");
      chk("ack", ack, CHANNEL_DMA_ACK_O);
      chk("addr", addr, SYS_ADDR_O);
      chk("ready", 1'b0, DMA_READY_O);
      IO_DEVICE_READY_I = 1'b1;
      wait_on(2, 1'b1, "ready_up");
      DMA_HOLD_REQUEST_I = 1'b0;
      IO_DEVICE_READY_I = 1'b0;
      wait_on(1, 1'b0, "release");
      CHANNEL_DMA_REQUEST_I = 8'h00;
      @(negedge CLOCK_I);
    end
  endtask
  task summarize;
    begin
      $display("compared %0d mismatches %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0)
        $display("ALL TESTS PASSED");
      else
        $display("TESTS FAILED");
      $finish;
    end
  endtask
  initial begin
    repeat (10) @(negedge CLOCK_I);
    RST_I = 1'b0;
    // past 255 so the wrap to zero is exercised
    for (i = 0; i < 258; i = i + 1) begin
      slow = i[0];
      refresh(i[7:0]);
    end
    $display("refresh test done");
    PERIPH_DATA_BUS_I = 8'ha5;
    PAGE_WRITE_I = 1'b1;
    @(negedge CLOCK_I) PAGE_WRITE_I = 1'b0;
    DMA_DATA_I = 8'h3c;
    DMA_UPPER_ADDR_STROBE_I = 1'b1;
    repeat (4) @(negedge CLOCK_I);
    DMA_UPPER_ADDR_STROBE_I = 1'b0;
    repeat (4) @(negedge CLOCK_I);
    // new data after the strobe must not reach the latch
    DMA_DATA_I = 8'hc3;
    DMA_ADDR_I = 16'hff77;
    dma(1'b0, 8'h02, 24'ha53c77);
    dma(1'b1, 8'h20, {7'h52, 8'h3c, 8'h77, 1'b0});
    $display("dma test done");
    MEM_DATA_BUS_I = 16'h2303;
    MEM_WRITE_I = 1'b1;
    @(negedge CLOCK_I) MEM_WRITE_I = 1'b0;
    chk("par_out", 3'b110, {PARITY_BIT_OE_O, PARITY_BIT_OUT_HI_O,
      PARITY_BIT_OUT_LO_O});
    // pass 0 clean, pass 1 low lane odd, pass 2 high lane odd
    for (i = 0; i < 3; i = i + 1) begin
      PARITY_BIT_IN_LO_I = (i == 1);
      PARITY_BIT_IN_HI_I = (i != 2);
      MEM_READ_I = 1'b1;
      @(negedge CLOCK_I) MEM_READ_I = 1'b0;
      chk("par_oe_read", 1'b0, PARITY_BIT_OE_O);
      repeat (3) @(negedge CLOCK_I);
      chk("err_nmi", {2{i != 0}}, {PARITY_ERROR_FLAG_O, NMI_O});
      if (i == 1) begin
        // clear so the high lane error is seen on its own
        ERROR_CLEAR_I = 1'b1;
        @(negedge CLOCK_I) ERROR_CLEAR_I = 1'b0;
        repeat (2) @(negedge CLOCK_I);
      end
    end
    STATUS_READ_I = 1'b1;
    @(negedge CLOCK_I) STATUS_READ_I = 1'b0;
    chk("status", 9'h180, {PERIPH_DATA_BUS_OE_O, PERIPH_DATA_BUS_O});
    ERROR_CLEAR_I = 1'b1;
    @(negedge CLOCK_I) ERROR_CLEAR_I = 1'b0;
    @(negedge CLOCK_I);
    chk("cleared", 2'b00, {PARITY_ERROR_FLAG_O, NMI_O});
    EXT_MEM_CHECK_N_I = 1'b0;
    wait_on(3, 1'b1, "nmi_ext");
    repeat (4) @(negedge CLOCK_I);
    EXT_MEM_CHECK_N_I = 1'b1;
    $display("parity test done");
    summarize;
  end
  initial begin
    repeat (20000) @(posedge CLOCK_I);
    failures = failures + 1;
    summarize;
  end
endmodule
